// *** logic/adcc_pkg.sv ***
/*
  Shared constants of the converter control port: widths, pipeline depth,
  pulse lengths, calibration length and clock-rate derived counts.
  Assumes a single system clock of 25 MHz on both ends.
*/
`default_nettype none
package adcc_pkg;
  localparam int DATA_W = 14;
  localparam int PIPE_DEPTH = 13;
  localparam int MIN_PULSE = 2;
  localparam int CAL_CYCLES = 32'h0004_29A0;
  localparam logic [13:0] NEG_FS = 14'h2000;
  localparam logic [13:0] POS_FS = 14'h1FFF;
  localparam int SYS_KHZ = 25000;
  localparam int CLK_NS = 40;
  localparam int CONV_MIN_KHZ = 300;
  localparam int CONV_MAX_KHZ = 2500;
  // Fastest legal converter clock as a division of the system clock
  localparam int CONV_DIV = SYS_KHZ / CONV_MAX_KHZ;
  // A converter clock period longer than the slowest legal one means it stopped
  localparam int STALL_CYC = (SYS_KHZ + CONV_MIN_KHZ - 1) / CONV_MIN_KHZ;
  localparam int HOLD_NS = 30;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_MS = 100;
  localparam int SETTLE_CYC = SETTLE_MS * SYS_KHZ;
  localparam int WAKE_CYC = 16;
endpackage : adcc_pkg
`default_nettype wire

// *** logic/adcc_if.sv ***
/*
  Pin-level link between the host capture logic and the converter.
  Assumes both ends run on the same system clock; the data bus level is
  resolved here from the converter's output enable.
*/
`timescale 1ns/100ps
`default_nettype none
interface adcc_if;
  logic conv_clk;
  logic conv_rst;
  logic cal;
  logic rd_n;
  logic power_down_n;
  logic [13:0] data_drv;
  logic data_oe;
  logic eoc_n;
  wire [13:0] data_bus;

  // A released bus reads as zero; the host only samples it while enabled
  assign data_bus = data_oe ? data_drv : 14'h0000;

  modport conv (
    input conv_clk, conv_rst, cal, rd_n, power_down_n,
    output data_drv, data_oe, eoc_n
  );
  modport host (
    output conv_clk, conv_rst, cal, rd_n, power_down_n,
    input data_bus, eoc_n
  );
endinterface : adcc_if
`default_nettype wire

// *** logic/adcc_conv.sv ***
/*
  Converter end: control sequencing (reset, calibration, power-down, wake),
  13-stage sample pipeline, valid indicator and three-state data output.
  Assumes the converter clock arrives as a pin from the host and is sampled
  on sys_clk; analog_in is the already digitised input, in LSBs of 14 bits.
*/
`timescale 1ns/100ps
`default_nettype none
module adcc_conv
  import adcc_pkg::*;
#(
  parameter int CAL_CYC = CAL_CYCLES,
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int STALL_CYCLES = STALL_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  adcc_if.conv lnk,
  input wire logic signed [15:0] analog_in,
  output logic powered_down,
  output logic calibrating,
  output logic calibrated
);
  typedef enum logic [1:0] {ST_PDOWN, ST_WAKE, ST_RUN, ST_CAL} adcc_state_t;

  adcc_state_t state_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic fall, stalled;
  logic [1:0] rst_hi_r, cal_hi_r;
  logic rst_done_r, cal_done_r;
  logic [31:0] cnt_r;
  logic [31:0] stall_r;
  logic [4:0] fill_r;
  logic [DATA_W-1:0] pipe_r [PIPE_DEPTH];
  logic [DATA_W-1:0] data_r;
  logic eoc_n_r, oe_r;

  // Clamp the input to the 14-bit two's complement range
  function automatic logic [DATA_W-1:0] adcc_sat(input logic signed [15:0] v);
    if (v < $signed(16'hE000)) begin
      return NEG_FS;
    end else if (v > $signed(16'h1FFF)) begin
      return POS_FS;
    end else begin
      return v[DATA_W-1:0];
    end
  endfunction : adcc_sat

  // Clock pin synchroniser; only the second and third stages feed logic
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else if (clk_en) begin
      ck_s1_r <= lnk.conv_clk;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  // Reset and calibrate are sequenced on the falling edge, where the host holds them; power-down and read act at once
  assign fall = ck_s3_r & ~ck_s2_r;

  // Watchdog on the converter clock
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (ck_s3_r != ck_s2_r) begin
        stall_r <= 32'h0000_0000;
      end else if (stall_r < STALL_CYCLES) begin
        stall_r <= stall_r + 32'h0000_0001;
      end
    end
  end
  assign stalled = (stall_r >= STALL_CYCLES);

  // Count how long reset and calibrate have been high, in converter clocks
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_hi_r <= 2'h0;
      cal_hi_r <= 2'h0;
    end else if (clk_en && fall) begin
      rst_hi_r <= !lnk.conv_rst ? 2'h0 : (rst_hi_r == 2'h2 ? 2'h2 : rst_hi_r + 2'h1);
      cal_hi_r <= !lnk.cal ? 2'h0 : (cal_hi_r == 2'h2 ? 2'h2 : cal_hi_r + 2'h1);
    end
  end

  // Power and calibration sequencing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_PDOWN;
      cnt_r <= 32'h0000_0000;
      rst_done_r <= 1'b0;
      cal_done_r <= 1'b0;
    end else if (clk_en) begin
      if (!lnk.power_down_n) begin
        // Acts on the system clock, so no converter clock is needed to idle
        state_r <= ST_PDOWN;
        rst_done_r <= 1'b0;
        cal_done_r <= 1'b0;
      end else begin
        case (state_r)
          ST_PDOWN: begin
            state_r <= ST_WAKE;
            cnt_r <= 32'h0000_0000;
          end
          ST_WAKE: begin
            if (fall) begin
              cnt_r <= cnt_r + 32'h0000_0001;
              // The host resets at once, so a pulse during wake-up must still count
              if (lnk.conv_rst && rst_hi_r == 2'h1) begin
                rst_done_r <= 1'b1;
              end
              if (cnt_r + 32'h0000_0001 >= WAKE_CYCLES) begin
                state_r <= ST_RUN;
              end
            end
          end
          ST_RUN: begin
            if (fall && lnk.conv_rst && rst_hi_r == 2'h1) begin
              rst_done_r <= 1'b1;
              cal_done_r <= 1'b0;
            end else if (fall && lnk.cal && cal_hi_r == 2'h1 && rst_done_r) begin
              // A calibrate request without a prior reset is ignored
              state_r <= ST_CAL;
              cnt_r <= 32'h0000_0000;
            end
          end
          ST_CAL: begin
            if (fall && lnk.conv_rst && rst_hi_r == 2'h1) begin
              state_r <= ST_RUN;
              cal_done_r <= 1'b0;
            end else if (fall) begin
              cnt_r <= cnt_r + 32'h0000_0001;
              if (cnt_r + 32'h0000_0001 >= CAL_CYC) begin
                state_r <= ST_RUN;
                cal_done_r <= 1'b1;
              end
            end
          end
          default: begin
            state_r <= ST_PDOWN;
          end
        endcase
      end
    end
  end

  // Pipeline fill: any disturbance restarts the 13-clock flush
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_r <= 5'h00;
    end else if (clk_en) begin
      if (state_r != ST_RUN || stalled || !lnk.power_down_n) begin
        fill_r <= 5'h00;
      end else if (fall) begin
        if (lnk.conv_rst || lnk.cal) begin
          fill_r <= 5'h00;
        end else if (fill_r < PIPE_DEPTH) begin
          fill_r <= fill_r + 5'h01;
        end
      end
    end
  end

  // Sample pipeline, one word in and one word out per converter clock
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= 14'h0000;
      end
      data_r <= 14'h0000;
    end else if (clk_en && fall) begin
      pipe_r[0] <= adcc_sat(analog_in);
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
      data_r <= pipe_r[PIPE_DEPTH-1];
    end
  end

  // Valid flag moves with the data word
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eoc_n_r <= 1'b1;
    end else if (clk_en) begin
      if (state_r != ST_RUN || stalled || !lnk.power_down_n || lnk.conv_rst) begin
        eoc_n_r <= 1'b1;
      end else if (fall) begin
        eoc_n_r <= !(fill_r == PIPE_DEPTH && !lnk.cal);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_r <= 1'b0;
    end else if (clk_en) begin
      oe_r <= !lnk.rd_n;
    end
  end

  assign lnk.data_drv = data_r;
  assign lnk.data_oe = oe_r;
  assign lnk.eoc_n = eoc_n_r;
  assign powered_down = (state_r == ST_PDOWN);
  assign calibrating = (state_r == ST_CAL);
  assign calibrated = cal_done_r;
endmodule : adcc_conv
`default_nettype wire

// *** logic/adcc_host.sv ***
/*
  Host end: makes the converter clock, runs the reset, settle, calibrate
  and flush sequence, handles power-down and captures valid words.
  Assumes the converter end is clocked from the same sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module adcc_host
  import adcc_pkg::*;
#(
  parameter int DIV = CONV_DIV,
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int CAL_CYC = CAL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  adcc_if.host lnk,
  input wire logic pd_req,
  input wire logic recal_req,
  output logic ready,
  output logic [13:0] sample_data,
  output logic sample_vld
);
  typedef enum logic [2:0] {H_PDOWN, H_RST, H_SETTLE, H_CAL, H_WAIT, H_READY} adcc_hstate_t;

  adcc_hstate_t state_r;
  logic [7:0] div_r;
  logic ck_r, rise, upd;
  logic [31:0] cnt_r;
  logic recal_r;
  logic [13:0] sample_r;
  logic vld_r;

  // Fixed divider: a free-running clock at a constant rate
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 8'h00;
      ck_r <= 1'b1;
    end else if (clk_en) begin
      div_r <= (div_r == 8'(DIV - 1)) ? 8'h00 : div_r + 8'h01;
      ck_r <= (div_r == 8'(DIV - 1)) || (div_r < 8'(DIV / 2 - 1));
    end
  end
  assign rise = (div_r == 8'h00) && ck_r;
  // Controls move a safe distance after the falling edge, never near it;
  // the far end sees that fall two synchroniser stages late, so wait those out too
  assign upd = (div_r == 8'(DIV / 2 + HOLD_CYC + 2));

  // Recalibration request is remembered until a control update in H_READY
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      recal_r <= 1'b0;
    end else if (clk_en) begin
      if (recal_req) begin
        recal_r <= 1'b1;
      end else if (upd && state_r == H_READY) begin
        recal_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= H_RST;
      cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state_r == H_SETTLE && cnt_r < SETTLE_CYCLES) begin
        cnt_r <= cnt_r + 32'h0000_0001;
      end
      if (upd) begin
        if (pd_req) begin
          state_r <= H_PDOWN;
          cnt_r <= 32'h0000_0000;
        end else begin
          case (state_r)
            H_PDOWN: begin
              state_r <= H_RST;
              cnt_r <= 32'h0000_0000;
            end
            H_RST: begin
              cnt_r <= cnt_r + 32'h0000_0001;
              if (cnt_r + 32'h0000_0001 >= MIN_PULSE) begin
                state_r <= H_SETTLE;
                cnt_r <= 32'h0000_0000;
              end
            end
            H_SETTLE: begin
              if (cnt_r >= SETTLE_CYCLES) begin
                state_r <= H_CAL;
                cnt_r <= 32'h0000_0000;
              end
            end
            H_CAL: begin
              cnt_r <= cnt_r + 32'h0000_0001;
              if (cnt_r + 32'h0000_0001 >= MIN_PULSE) begin
                state_r <= H_WAIT;
                cnt_r <= 32'h0000_0000;
              end
            end
            H_WAIT: begin
              cnt_r <= cnt_r + 32'h0000_0001;
              // No done flag exists, so wait out calibration and the flush
              if (cnt_r + 32'h0000_0001 >= CAL_CYC + PIPE_DEPTH) begin
                state_r <= H_READY;
              end
            end
            H_READY: begin
              if (recal_r) begin
                state_r <= H_RST;
                cnt_r <= 32'h0000_0000;
              end
            end
            default: begin
              state_r <= H_RST;
            end
          endcase
        end
      end
    end
  end

  // Capture on the rising converter clock edge, three system clocks after the word changes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_r <= 14'h0000;
      vld_r <= 1'b0;
    end else if (clk_en) begin
      vld_r <= 1'b0;
      if (rise && state_r == H_READY && !lnk.eoc_n) begin
        sample_r <= lnk.data_bus;
        vld_r <= 1'b1;
      end
    end
  end

  assign lnk.conv_clk = ck_r;
  assign lnk.conv_rst = (state_r == H_RST);
  assign lnk.cal = (state_r == H_CAL);
  assign lnk.power_down_n = (state_r != H_PDOWN);
  assign lnk.rd_n = (state_r != H_READY);
  assign ready = (state_r == H_READY);
  assign sample_data = sample_r;
  assign sample_vld = vld_r;
endmodule : adcc_host
`default_nettype wire

// *** tb/adcc_chk_sva.sv ***
/*
  Checker for the link between host and converter: control pulses,
  control hold at the clock fall, valid flag, output enable, word rate.
  Assumes both ends share sys_clk and it sits beside the interface.
*/
`timescale 1ns/100ps
`default_nettype none
module adcc_chk #(
  parameter int CAL_CYC = 40
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic conv_clk,
  input wire logic conv_rst,
  input wire logic cal,
  input wire logic rd_n,
  input wire logic power_down_n,
  input wire logic [13:0] data_drv,
  input wire logic data_oe,
  input wire logic eoc_n
);
  localparam int FLUSH = 13;
  logic [1:0] rst_falls_r;
  logic [1:0] cal_falls_r;
  logic [15:0] ctl_falls_r;
  logic [15:0] cal_since_r;
  logic [3:0] pd_cnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Falls are counted one sys clock late, so the bounds keep some slack
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_falls_r <= 2'h0;
      cal_falls_r <= 2'h0;
      ctl_falls_r <= 16'h0000;
      cal_since_r <= 16'h0000;
      pd_cnt_r <= 4'h0;
    end else begin
      rst_falls_r <= !conv_rst ? 2'h0 : rst_falls_r + 2'(($fell(conv_clk) && rst_falls_r != 2'h3));
      cal_falls_r <= !cal ? 2'h0 : cal_falls_r + 2'(($fell(conv_clk) && cal_falls_r != 2'h3));
      ctl_falls_r <= (conv_rst || cal) ? 16'h0000 :
        ctl_falls_r + 16'(($fell(conv_clk) && ctl_falls_r != 16'hFFFF));
      cal_since_r <= cal ? 16'h0000 : cal_since_r + 16'(($fell(conv_clk) && cal_since_r != 16'hFFFF));
      pd_cnt_r <= power_down_n ? 4'h0 : pd_cnt_r + 4'((pd_cnt_r != 4'hF));
    end
  end
  a_rst_two_clocks: assert property ($fell(conv_rst) |-> rst_falls_r >= 2'h2)
    else $error("reset pulse shorter than two clocks");
  a_cal_two_clocks: assert property ($fell(cal) |-> cal_falls_r >= 2'h2)
    else $error("calibrate pulse shorter than two clocks");
  a_rst_no_valid: assert property (rst_falls_r >= 2'h2 |-> eoc_n)
    else $error("valid flag low during reset");
  a_cal_occupies: assert property (cal_since_r < 16'(CAL_CYC - 2) |-> eoc_n)
    else $error("valid flag low during calibration");
  a_flush_after_ctl: assert property (ctl_falls_r < 16'(FLUSH) |-> eoc_n)
    else $error("valid flag low inside pipeline flush");
  a_ctrl_hold_fall: assert property ($fell(conv_clk) |-> $stable(conv_rst) && $stable(cal) &&
    $stable(rd_n) && $stable(power_down_n))
    else $error("control changed at clock fall");
  a_oe_follows_rd: assert property ($changed(rd_n) |=> data_oe != $past(rd_n))
    else $error("output enable does not follow read enable");
  a_pd_no_valid: assert property (pd_cnt_r >= 4'h8 |-> eoc_n)
    else $error("valid flag low in power-down");
  a_one_word: assert property (!eoc_n && $changed(data_drv) |=> $stable(data_drv)[*8])
    else $error("more than one word per clock");
  cover property ($fell(eoc_n));
  cover property ($fell(cal));
  cover property ($fell(power_down_n));
  cover property ($rose(power_down_n));
endmodule : adcc_chk
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Testbench joining host and converter ends: bring-up, sample words,
  saturation, pipeline delay, word rate, power-down and recalibration.
  Assumes a shortened settle count on the host and shortened calibration counts on both ends.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int CALN = 40;
  logic sys_clk;
  logic sys_rst;
  logic run_en;
  logic signed [15:0] analog_in;
  logic pd_req, recal_req, powered_down, calibrating, calibrated, ready, sample_vld;
  logic [13:0] sample_data;
  logic [13:0] got;
  int bad_count;
  int samples_checked;
  int n;
  logic [15:0] ain_tab [7] = '{16'h0000, 16'h0064, 16'hE000, 16'h1FFF, 16'hDCD8, 16'h2328, 16'hFFFF};
  logic [13:0] exp_tab [7] = '{14'h0000, 14'h0064, 14'h2000, 14'h1FFF, 14'h2000, 14'h1FFF, 14'h3FFF};
  adcc_if adcc_if_inst ();
  adcc_conv #(.CAL_CYC(CALN), .WAKE_CYCLES(4)) adcc_conv_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(run_en), .lnk(adcc_if_inst), .analog_in(analog_in),
    .powered_down(powered_down), .calibrating(calibrating), .calibrated(calibrated));
  adcc_host #(.SETTLE_CYCLES(50), .CAL_CYC(CALN)) adcc_host_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(run_en), .lnk(adcc_if_inst), .pd_req(pd_req),
    .recal_req(recal_req), .ready(ready), .sample_data(sample_data), .sample_vld(sample_vld));
  adcc_chk #(.CAL_CYC(CALN)) adcc_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .conv_clk(adcc_if_inst.conv_clk), .conv_rst(adcc_if_inst.conv_rst), .cal(adcc_if_inst.cal),
    .rd_n(adcc_if_inst.rd_n), .power_down_n(adcc_if_inst.power_down_n),
    .data_drv(adcc_if_inst.data_drv), .data_oe(adcc_if_inst.data_oe), .eoc_n(adcc_if_inst.eoc_n));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Bounded wait on ready (sel 0) or powered_down (sel 1)
  task automatic wait_on(input string what, input int sel, input logic lvl);
    int k;
    k = 0;
    while (((sel == 0) ? ready : powered_down) !== lvl && k < 5000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 5000) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen timeout", what, lvl);
      tally_and_finish();
    end
  endtask : wait_on
  task automatic next_word(output logic [13:0] d);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (sample_vld !== 1'b1 && k < 500) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 500) begin
      bad_count++;
      $display("[FAIL] sample_vld expected 1 seen timeout");
      tally_and_finish();
    end
    d = sample_data;
  endtask : next_word
  initial begin
    sys_rst = 1'b1;
    run_en = 1'b1;
    analog_in = 16'h0000;
    pd_req = 1'b0;
    recal_req = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("conv_rst", 14'h0001, adcc_if_inst.conv_rst);
    chk("eoc_n", 14'h0001, adcc_if_inst.eoc_n);
    chk("data_oe", 14'h0000, adcc_if_inst.data_oe);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_on("ready", 0, 1'b1);
    chk("calibrated", 14'h0001, calibrated);
    // Output enable trails the read enable by one clock
    @(negedge sys_clk);
    chk("data_oe", 14'h0001, adcc_if_inst.data_oe);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      analog_in <= ain_tab[i];
      repeat (16) next_word(got);
      chk("sample", exp_tab[i], got);
    end
    // New value lands right after a capture, before the next fall
    next_word(got);
    @(posedge sys_clk);
    analog_in <= 16'h04D2;
    repeat (13) next_word(got);
    chk("sample_old", 14'h3FFF, got);
    next_word(got);
    chk("sample_new", 14'h04D2, got);
    n = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (sample_vld === 1'b1) n++;
    end
    chk("word_rate", 14'h0014, 14'(n));
    // A low clock enable stops both ends; nothing may move meanwhile
    @(posedge sys_clk);
    run_en <= 1'b0;
    @(negedge sys_clk);
    got = sample_data;
    n = 0;
    repeat (50) begin
      @(negedge sys_clk);
      if (sample_vld === 1'b1) n++;
    end
    chk("frozen_words", 14'h0000, 14'(n));
    chk("frozen_data", got, sample_data);
    @(posedge sys_clk);
    run_en <= 1'b1;
    @(posedge sys_clk);
    pd_req <= 1'b1;
    wait_on("powered_down", 1, 1'b1);
    repeat (200) @(negedge sys_clk);
    chk("power_down_n", 14'h0000, adcc_if_inst.power_down_n);
    chk("eoc_n", 14'h0001, adcc_if_inst.eoc_n);
    chk("calibrated", 14'h0000, calibrated);
    chk("data_oe", 14'h0000, adcc_if_inst.data_oe);
    @(posedge sys_clk);
    pd_req <= 1'b0;
    wait_on("powered_down", 1, 1'b0);
    wait_on("ready", 0, 1'b1);
    chk("calibrated", 14'h0001, calibrated);
    repeat (16) next_word(got);
    chk("sample", 14'h04D2, got);
    @(posedge sys_clk);
    recal_req <= 1'b1;
    @(posedge sys_clk);
    recal_req <= 1'b0;
    wait_on("ready", 0, 1'b0);
    wait_on("ready", 0, 1'b1);
    chk("calibrating", 14'h0000, calibrating);
    repeat (16) next_word(got);
    chk("sample", 14'h04D2, got);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
